// ==== rtl/flash_erase_program.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_erase_program #(
   parameter int T_SMALL_NS = 100000,
   parameter int T_HALF_NS = 200000,
   parameter int T_BLK64_NS = 400000,
   parameter int T_WHOLE_NS = 800000,
   parameter int T_PAGE_NS = 50000
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic flash_sclk,
   input wire logic cs_n,
   input wire logic [3:0] quad_io_lines,
   input wire logic [4:0] protect_range_bits,
   output logic write_unlock_flag,
   output logic operation_pending_flag,
   output logic array_clr_valid,
   output flash_seq_pkg::clr_kind_t array_clr_kind,
   output logic [23:0] array_clr_addr,
   output logic array_wr_valid,
   output logic [23:0] array_wr_addr,
   output logic [7:0] array_wr_data
);

   // least times round up to whole cycles
   localparam int CYC_SMALL = (T_SMALL_NS + flash_seq_pkg::SYS_CLK_NS - 1)
      / flash_seq_pkg::SYS_CLK_NS;
   localparam int CYC_HALF = (T_HALF_NS + flash_seq_pkg::SYS_CLK_NS - 1)
      / flash_seq_pkg::SYS_CLK_NS;
   localparam int CYC_BLK64 = (T_BLK64_NS + flash_seq_pkg::SYS_CLK_NS - 1)
      / flash_seq_pkg::SYS_CLK_NS;
   localparam int CYC_WHOLE = (T_WHOLE_NS + flash_seq_pkg::SYS_CLK_NS - 1)
      / flash_seq_pkg::SYS_CLK_NS;
   localparam int CYC_PAGE = (T_PAGE_NS + flash_seq_pkg::SYS_CLK_NS - 1)
      / flash_seq_pkg::SYS_CLK_NS;

   // ------------------------------------------------------------
   // link side: frame capture on the serial clock
   // ------------------------------------------------------------
   logic frame_rst_n;
   logic in_frame_reg;
   logic [5:0] hdr_reg, hdr_next;
   logic [7:0] opc_reg, opc_next;
   logic [23:0] addr_reg, addr_next;
   logic [7:0] shift_reg, shift_next;
   logic [2:0] bitpos_reg, bitpos_next;
   logic [8:0] bytes_reg, bytes_next;
   logic [7:0] widx_reg, widx_next;
   logic mem_we;
   logic busy_l1_reg, busy_l2_reg;
   logic [7:0] page_mem [256];

   // chip select high holds the frame flag clear, so the next edge restarts counting
   assign frame_rst_n = arst_n & ~cs_n;

   always_ff @(posedge flash_sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         in_frame_reg <= 1'b0;
      end else begin
         in_frame_reg <= 1'b1;
      end
   end

   // opcode then address on line zero, data serial or four wide
   always_comb begin
      hdr_next = hdr_reg;
      opc_next = opc_reg;
      addr_next = addr_reg;
      shift_next = shift_reg;
      bitpos_next = bitpos_reg;
      bytes_next = bytes_reg;
      widx_next = widx_reg;
      mem_we = 1'b0;
      if (!in_frame_reg) begin
         hdr_next = 6'h01;
         opc_next = {7'h00, quad_io_lines[0]};
         bitpos_next = 3'h0;
         bytes_next = 9'h000;
      end else if (hdr_reg < flash_seq_pkg::HDR_OPC_CLKS) begin
         hdr_next = hdr_reg + 6'h01;
         opc_next = {opc_reg[6:0], quad_io_lines[0]};
      end else if (hdr_reg < flash_seq_pkg::HDR_ALL_CLKS) begin
         hdr_next = hdr_reg + 6'h01;
         addr_next = {addr_reg[22:0], quad_io_lines[0]};
         if (hdr_reg == flash_seq_pkg::HDR_LAST_ADDR) begin
            widx_next = {addr_reg[6:0], quad_io_lines[0]};
         end
      end else begin
         if (opc_reg == flash_seq_pkg::OPC_QPAGE) begin
            shift_next = {shift_reg[3:0], quad_io_lines};
            bitpos_next = bitpos_reg + flash_seq_pkg::QUAD_STEP;
         end else begin
            shift_next = {shift_reg[6:0], quad_io_lines[0]};
            bitpos_next = bitpos_reg + flash_seq_pkg::SER_STEP;
         end
         if (bitpos_next == 3'h0) begin
            mem_we = !busy_l2_reg;
            widx_next = widx_reg + 8'h01;
            if (bytes_reg != flash_seq_pkg::PAGE_BYTES) begin
               bytes_next = bytes_reg + 9'h001;
            end
         end
      end
   end

   // counters are not cleared by chip select: the system side reads them after the frame
   always_ff @(posedge flash_sclk or negedge arst_n) begin
      if (!arst_n) begin
         hdr_reg <= 6'h00;
         opc_reg <= 8'h00;
         addr_reg <= 24'h000000;
         shift_reg <= 8'h00;
         bitpos_reg <= 3'h0;
         bytes_reg <= 9'h000;
         widx_reg <= 8'h00;
         busy_l1_reg <= 1'b0;
         busy_l2_reg <= 1'b0;
      end else begin
         hdr_reg <= hdr_next;
         opc_reg <= opc_next;
         addr_reg <= addr_next;
         shift_reg <= shift_next;
         bitpos_reg <= bitpos_next;
         bytes_reg <= bytes_next;
         widx_reg <= widx_next;
         busy_l1_reg <= operation_pending_flag;
         busy_l2_reg <= busy_l1_reg;
      end
   end

   // wrapping write index overwrites oldest bytes, keeping the newest page
   always_ff @(posedge flash_sclk) begin
      if (mem_we) begin
         page_mem[widx_reg] <= shift_next;
      end
   end

   // ------------------------------------------------------------
   // system side: frame end detection
   // ------------------------------------------------------------
   logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
   logic cs_rise;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cs_s1_reg <= 1'b1;
         cs_s2_reg <= 1'b1;
         cs_s3_reg <= 1'b1;
      end else begin
         cs_s1_reg <= cs_n;
         cs_s2_reg <= cs_s1_reg;
         cs_s3_reg <= cs_s2_reg;
      end
   end

   // link registers are quiet once chip select is high, so reading them here is safe
   assign cs_rise = cs_s2_reg & ~cs_s3_reg;

   logic opc_len_ok, addr_len_ok, prog_len_ok;
   logic is_small, is_half, is_blk64, is_whole, is_prog;
   logic hit_small, hit_half, hit_blk64, hit_page;

   assign opc_len_ok = (hdr_reg == flash_seq_pkg::HDR_OPC_CLKS);
   assign addr_len_ok = (hdr_reg == flash_seq_pkg::HDR_ALL_CLKS) && (bitpos_reg == 3'h0)
      && (bytes_reg == 9'h000);
   assign prog_len_ok = (hdr_reg == flash_seq_pkg::HDR_ALL_CLKS) && (bitpos_reg == 3'h0)
      && (bytes_reg != 9'h000);
   assign is_small = (opc_reg == flash_seq_pkg::OPC_SMALL);
   assign is_half = (opc_reg == flash_seq_pkg::OPC_HALF);
   assign is_blk64 = (opc_reg == flash_seq_pkg::OPC_BLK64);
   assign is_whole = (opc_reg == flash_seq_pkg::OPC_WHOLE_A)
      || (opc_reg == flash_seq_pkg::OPC_WHOLE_B);
   assign is_prog = (opc_reg == flash_seq_pkg::OPC_PAGE)
      || (opc_reg == flash_seq_pkg::OPC_QPAGE);
   assign hit_small = flash_seq_pkg::prot_hit(protect_range_bits,
      addr_reg | flash_seq_pkg::SMALL_MASK);
   assign hit_half = flash_seq_pkg::prot_hit(protect_range_bits,
      addr_reg | flash_seq_pkg::HALF_MASK);
   assign hit_blk64 = flash_seq_pkg::prot_hit(protect_range_bits,
      addr_reg | flash_seq_pkg::BLK64_MASK);
   assign hit_page = flash_seq_pkg::prot_hit(protect_range_bits,
      addr_reg | flash_seq_pkg::PAGE_MASK);

   // ------------------------------------------------------------
   // system side: command sequencer
   // ------------------------------------------------------------
   flash_seq_pkg::seq_state_t state_reg, state_next;
   logic unlock_reg, unlock_next;
   logic pend_reg, pend_next;
   logic clr_valid_reg, clr_valid_next;
   flash_seq_pkg::clr_kind_t clr_kind_reg, clr_kind_next;
   logic [23:0] clr_addr_reg, clr_addr_next;
   logic wr_valid_reg, wr_valid_next;
   logic [23:0] wr_addr_reg, wr_addr_next;
   logic [7:0] wr_data_reg, wr_data_next;
   logic [15:0] page_reg, page_next;
   logic [7:0] ridx_reg, ridx_next;
   logic [8:0] left_reg, left_next;
   logic tmr_start;
   logic [31:0] tmr_load;
   logic tmr_done;

   always_comb begin
      state_next = state_reg;
      unlock_next = unlock_reg;
      clr_valid_next = 1'b0;
      clr_kind_next = clr_kind_reg;
      clr_addr_next = clr_addr_reg;
      wr_valid_next = 1'b0;
      wr_addr_next = wr_addr_reg;
      wr_data_next = wr_data_reg;
      page_next = page_reg;
      ridx_next = ridx_reg;
      left_next = left_reg;
      tmr_start = 1'b0;
      tmr_load = 32'h00000000;
      unique case (state_reg)
         flash_seq_pkg::ST_IDLE: begin
            if (cs_rise) begin
               if (opc_len_ok && opc_reg == flash_seq_pkg::OPC_UNLOCK) begin
                  unlock_next = 1'b1;
               end else if (!unlock_reg) begin
                  state_next = flash_seq_pkg::ST_IDLE;
               end else if (addr_len_ok && is_small && !hit_small) begin
                  clr_valid_next = 1'b1;
                  clr_kind_next = flash_seq_pkg::CLR_SMALL;
                  clr_addr_next = addr_reg & ~flash_seq_pkg::SMALL_MASK;
                  tmr_start = 1'b1;
                  tmr_load = 32'(CYC_SMALL);
                  state_next = flash_seq_pkg::ST_TIMED;
               end else if (addr_len_ok && is_half) begin
                  if (hit_half) begin
                     unlock_next = 1'b0;
                  end else begin
                     clr_valid_next = 1'b1;
                     clr_kind_next = flash_seq_pkg::CLR_HALF;
                     clr_addr_next = addr_reg & ~flash_seq_pkg::HALF_MASK;
                     tmr_start = 1'b1;
                     tmr_load = 32'(CYC_HALF);
                     state_next = flash_seq_pkg::ST_TIMED;
                  end
               end else if (addr_len_ok && is_blk64 && !hit_blk64) begin
                  clr_valid_next = 1'b1;
                  clr_kind_next = flash_seq_pkg::CLR_BLK64;
                  clr_addr_next = addr_reg & ~flash_seq_pkg::BLK64_MASK;
                  tmr_start = 1'b1;
                  tmr_load = 32'(CYC_BLK64);
                  state_next = flash_seq_pkg::ST_TIMED;
               end else if (opc_len_ok && is_whole
                  && protect_range_bits == flash_seq_pkg::PROT_NONE) begin
                  clr_valid_next = 1'b1;
                  clr_kind_next = flash_seq_pkg::CLR_WHOLE;
                  clr_addr_next = 24'h000000;
                  tmr_start = 1'b1;
                  tmr_load = 32'(CYC_WHOLE);
                  state_next = flash_seq_pkg::ST_TIMED;
               end else if (prog_len_ok && is_prog && !hit_page) begin
                  page_next = addr_reg[23:8];
                  // a full page starts at offset zero, a short one at the address
                  ridx_next = (bytes_reg == flash_seq_pkg::PAGE_BYTES) ? 8'h00
                     : addr_reg[7:0];
                  left_next = bytes_reg;
                  state_next = flash_seq_pkg::ST_STREAM;
               end
            end
         end
         flash_seq_pkg::ST_STREAM: begin
            wr_valid_next = 1'b1;
            wr_addr_next = {page_reg, ridx_reg};
            wr_data_next = page_mem[ridx_reg];
            ridx_next = ridx_reg + 8'h01;
            left_next = left_reg - 9'h001;
            if (left_reg == 9'h001) begin
               tmr_start = 1'b1;
               tmr_load = 32'(CYC_PAGE);
               state_next = flash_seq_pkg::ST_TIMED;
            end
         end
         flash_seq_pkg::ST_TIMED: begin
            if (tmr_done) begin
               unlock_next = 1'b0;
               state_next = flash_seq_pkg::ST_IDLE;
            end
         end
         default: begin
            state_next = flash_seq_pkg::ST_IDLE;
         end
      endcase
      pend_next = (state_next != flash_seq_pkg::ST_IDLE);
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= flash_seq_pkg::ST_IDLE;
         unlock_reg <= 1'b0;
         pend_reg <= 1'b0;
         clr_valid_reg <= 1'b0;
         clr_kind_reg <= flash_seq_pkg::CLR_SMALL;
         clr_addr_reg <= 24'h000000;
         wr_valid_reg <= 1'b0;
         wr_addr_reg <= 24'h000000;
         wr_data_reg <= 8'h00;
         page_reg <= 16'h0000;
         ridx_reg <= 8'h00;
         left_reg <= 9'h000;
      end else begin
         state_reg <= state_next;
         unlock_reg <= unlock_next;
         pend_reg <= pend_next;
         clr_valid_reg <= clr_valid_next;
         clr_kind_reg <= clr_kind_next;
         clr_addr_reg <= clr_addr_next;
         wr_valid_reg <= wr_valid_next;
         wr_addr_reg <= wr_addr_next;
         wr_data_reg <= wr_data_next;
         page_reg <= page_next;
         ridx_reg <= ridx_next;
         left_reg <= left_next;
      end
   end

   op_timer #(.W(32)) u_timer (
      .clk(sys_clk),
      .arst_n(arst_n),
      .start(tmr_start),
      .load(tmr_load),
      .busy(),
      .done(tmr_done)
   );

   assign write_unlock_flag = unlock_reg;
   assign operation_pending_flag = pend_reg;
   assign array_clr_valid = clr_valid_reg;
   assign array_clr_kind = clr_kind_reg;
   assign array_clr_addr = clr_addr_reg;
   assign array_wr_valid = wr_valid_reg;
   assign array_wr_addr = wr_addr_reg;
   assign array_wr_data = wr_data_reg;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [15:0] last_page_reg;
   logic [9:0] run_reg;
   logic idle_now;

   assign idle_now = (state_reg == flash_seq_pkg::ST_IDLE);

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         last_page_reg <= 16'h0000;
         run_reg <= 10'h000;
      end else begin
         last_page_reg <= array_wr_addr[23:8];
         run_reg <= array_wr_valid ? run_reg + 10'h001 : 10'h000;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   sequence s_accept_prog;
      cs_rise && idle_now && unlock_reg && prog_len_ok && is_prog && !hit_page;
   endsequence
   sequence s_stream_run;
      array_wr_valid ##1 array_wr_valid;
   endsequence

   property p_prog_starts;
      s_accept_prog |-> ##1 operation_pending_flag ##1 array_wr_valid;
   endproperty
   a_prog_starts: assert property (p_prog_starts) else $error("program not started");
   property p_done_clears;
      tmr_done |=> !operation_pending_flag && !write_unlock_flag;
   endproperty
   a_done_clears: assert property (p_done_clears) else $error("flags not cleared");
   property p_locked_ignored;
      cs_rise && idle_now && !unlock_reg |-> ##1 !array_clr_valid ##1 !array_wr_valid;
   endproperty
   a_locked_ignored: assert property (p_locked_ignored) else $error("locked cmd ran");
   property p_whole_prot;
      cs_rise && is_whole && protect_range_bits != flash_seq_pkg::PROT_NONE |=> !array_clr_valid;
   endproperty
   a_whole_prot: assert property (p_whole_prot) else $error("whole clear under protect");
   property p_half_prot;
      cs_rise && idle_now && unlock_reg && addr_len_ok && is_half && hit_half
         |=> !write_unlock_flag && !array_clr_valid && !operation_pending_flag;
   endproperty
   a_half_prot: assert property (p_half_prot) else $error("protected half block");
   property p_bad_frame;
      cs_rise && (is_small || is_blk64 || is_half) && !addr_len_ok |=> !array_clr_valid;
   endproperty
   a_bad_frame: assert property (p_bad_frame) else $error("misframed clear ran");
   property p_page_fixed;
      s_stream_run |-> array_wr_addr[23:8] == last_page_reg;
   endproperty
   a_page_fixed: assert property (p_page_fixed) else $error("write left the page");
   property p_stream_len;
      array_wr_valid |-> run_reg < 10'h100;
   endproperty
   a_stream_len: assert property (p_stream_len) else $error("more than a page");
   property p_sector_base;
      array_clr_valid && array_clr_kind == flash_seq_pkg::CLR_SMALL
         |-> array_clr_addr[11:0] == 12'h000 && !write_unlock_flag == 1'b0;
   endproperty
   a_sector_base: assert property (p_sector_base) else $error("sector base wrong");

endmodule
`default_nettype wire

// ==== rtl/flash_seq_pkg.sv ====
`default_nettype none
package flash_seq_pkg;

   // ------------------------------------------------------------
   // opcodes
   // ------------------------------------------------------------
   localparam logic [7:0] OPC_UNLOCK = 8'h06;
   localparam logic [7:0] OPC_SMALL = 8'h20;
   localparam logic [7:0] OPC_HALF = 8'h52;
   localparam logic [7:0] OPC_BLK64 = 8'hd8;
   localparam logic [7:0] OPC_WHOLE_A = 8'h60;
   localparam logic [7:0] OPC_WHOLE_B = 8'hc7;
   localparam logic [7:0] OPC_PAGE = 8'h02;
   localparam logic [7:0] OPC_QPAGE = 8'h32;

   // ------------------------------------------------------------
   // frame layout, geometry and timing
   // ------------------------------------------------------------
   localparam logic [5:0] HDR_OPC_CLKS = 6'h08;
   localparam logic [5:0] HDR_ALL_CLKS = 6'h20;
   localparam logic [5:0] HDR_LAST_ADDR = 6'h1f;
   localparam logic [8:0] PAGE_BYTES = 9'h100;
   localparam logic [2:0] SER_STEP = 3'h1;
   localparam logic [2:0] QUAD_STEP = 3'h4;
   localparam logic [23:0] SMALL_MASK = 24'h000fff;
   localparam logic [23:0] HALF_MASK = 24'h007fff;
   localparam logic [23:0] BLK64_MASK = 24'h00ffff;
   localparam logic [23:0] PAGE_MASK = 24'h0000ff;
   localparam logic [24:0] ARRAY_TOP = 25'h1000000;
   localparam logic [24:0] PROT_UNIT = 25'h0010000;
   localparam logic [4:0] PROT_NONE = 5'h00;
   localparam logic [4:0] PROT_ALL = 5'h09;
   localparam int SYS_CLK_NS = 8;

   typedef enum logic [1:0] {
      CLR_SMALL = 2'h0,
      CLR_HALF = 2'h1,
      CLR_BLK64 = 2'h2,
      CLR_WHOLE = 2'h3
   } clr_kind_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_STREAM = 3'b010,
      ST_TIMED = 3'b100
   } seq_state_t;

   // protected region grows down from the top, starting at 64K and doubling at each step
   function automatic logic prot_hit(input logic [4:0] bp, input logic [23:0] last);
      logic [24:0] start;
      start = 25'h0000000;
      if (bp == PROT_NONE) begin
         prot_hit = 1'b0;
      end else if (bp >= PROT_ALL) begin
         prot_hit = 1'b1;
      end else begin
         start = ARRAY_TOP - (PROT_UNIT << (bp - 5'h01));
         prot_hit = ({1'b0, last} >= start);
      end
   endfunction

endpackage
`default_nettype wire

// ==== rtl/op_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module op_timer #(
   parameter int W = 32
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic start,
   input wire logic [W-1:0] load,
   output logic busy,
   output logic done
);

   logic [W-1:0] cnt_reg, cnt_next;
   logic busy_reg, busy_next;
   logic done_reg, done_next;

   // ------------------------------------------------------------
   // down counter; load of zero still lasts one cycle
   // ------------------------------------------------------------
   always_comb begin
      cnt_next = cnt_reg;
      busy_next = busy_reg;
      done_next = 1'b0;
      if (start) begin
         cnt_next = load;
         busy_next = 1'b1;
      end else if (busy_reg) begin
         if (cnt_reg <= W'(1)) begin
            busy_next = 1'b0;
            done_next = 1'b1;
         end else begin
            cnt_next = cnt_reg - W'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= '0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
      end
   end

   assign busy = busy_reg;
   assign done = done_reg;

endmodule
`default_nettype wire

// ==== rtl/_unused_guard.sv ====
`default_nettype none
`default_nettype wire

// ==== tb/flash_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// host controller model; link clock runs only inside frames
module flash_host (
   output logic flash_sclk,
   output logic cs_n,
   output logic [3:0] quad_io_lines
);
   initial begin
      flash_sclk = 1'b0;
      cs_n = 1'b1;
      quad_io_lines = 4'h0;
   end
   // data byte pattern; bit 8 folded in so early and late bytes differ
   function automatic logic [7:0] dj(input int j);
      return j[7:0] ^ {7'h0, j[8]};
   endfunction
   // one link clock, lines set half a period ahead of the rise
   task automatic tick(input logic [3:0] v);
      quad_io_lines = v;
      #62.5 flash_sclk = 1'b1;
      #62.5 flash_sclk = 1'b0;
   endtask
   // upper lines toggle so that ignoring them is tested
   task automatic ser(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) tick({~b[i], b[i], ~b[i], b[i]});
   endtask
   // whole frame: opcode, address, data, optional stray bits
   task automatic frame(input logic [7:0] op, input logic [23:0] a, input bit ad,
         input int nd, input int xb);
      logic [7:0] d;
      cs_n = 1'b0;
      ser(op);
      if (ad) for (int i = 2; i >= 0; i--) ser(a[8*i+:8]);
      for (int j = 0; j < nd; j++) begin
         d = dj(j);
         if (op == 8'h32) begin
            tick(d[7:4]);
            tick(d[3:0]);
         end else ser(d);
      end
      for (int j = 0; j < xb; j++) tick(4'h0);
      #62.5 cs_n = 1'b1;
      quad_io_lines = ~quad_io_lines; // released lines do not hold
   endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic sys_clk, arst_n, flash_sclk, cs_n, write_unlock_flag, operation_pending_flag;
   logic array_clr_valid, array_wr_valid, pend;
   logic [3:0] quad_io_lines;
   logic [4:0] protect_range_bits;
   flash_seq_pkg::clr_kind_t array_clr_kind;
   logic [23:0] array_clr_addr, array_wr_addr;
   logic [7:0] array_wr_data;
   logic [7:0] ops [7] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h02, 8'h32};
   logic [25:0] ex [5] = '{26'h001a000, 26'h1018000, 26'h2010000, 26'h3000000, 26'h3000000};
   logic [31:0] wq [$];
   int errors, n_tests, n_clr;
   flash_host h (.flash_sclk(flash_sclk), .cs_n(cs_n), .quad_io_lines(quad_io_lines));
   // short timed cycles keep the run small
   flash_erase_program #(.T_SMALL_NS(80), .T_HALF_NS(80), .T_BLK64_NS(80), .T_WHOLE_NS(80),
         .T_PAGE_NS(80)) DUT (.sys_clk(sys_clk), .arst_n(arst_n), .flash_sclk(flash_sclk),
         .cs_n(cs_n), .quad_io_lines(quad_io_lines), .protect_range_bits(protect_range_bits),
         .write_unlock_flag(write_unlock_flag), .operation_pending_flag(operation_pending_flag),
         .array_clr_valid(array_clr_valid), .array_clr_kind(array_clr_kind),
         .array_clr_addr(array_clr_addr), .array_wr_valid(array_wr_valid),
         .array_wr_addr(array_wr_addr), .array_wr_data(array_wr_data));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // array side capture, sampled mid-cycle
   always @(negedge sys_clk) begin
      if (array_clr_valid === 1'b1) begin
         n_clr++;
         wq.push_back({6'h0, array_clr_kind, array_clr_addr});
      end
      if (array_wr_valid === 1'b1) wq.push_back({array_wr_addr, array_wr_data});
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // one framed command, then a bounded wait for the timed cycle to end
   task automatic cmd(input logic [7:0] op, input logic [23:0] a, input bit ad, input int nd,
         input int xb, input logic [4:0] bp);
      int k;
      @(negedge sys_clk) protect_range_bits = bp;
      n_clr = 0;
      wq.delete();
      h.frame(op, a, ad, nd, xb);
      repeat (8) @(negedge sys_clk);
      pend = operation_pending_flag;
      k = 0;
      while (operation_pending_flag !== 1'b0 && k < 2000) begin
         @(negedge sys_clk);
         k++;
      end
      if (k == 2000) begin
         errors++;
         finish_test();
      end
      repeat (4) @(negedge sys_clk);
   endtask
   task automatic unl();
      cmd(8'h06, 24'h0, 1'b0, 0, 0, 5'h00);
      chk(write_unlock_flag, 1'b1);
   endtask
   initial begin
      errors = 0;
      n_tests = 0;
      arst_n = 1'b0;
      protect_range_bits = 5'h00;
      repeat (20) @(negedge sys_clk);
      arst_n = 1'b1;
      chk({write_unlock_flag, operation_pending_flag, array_wr_valid}, 32'h0);
      for (int i = 0; i < 5; i++) begin
         unl();
         cmd(ops[i], 24'h01a345, i < 3, 0, 0, 5'h00);
         chk(n_clr, 1);
         chk(wq[0], {6'h0, ex[i]});
         chk({pend, write_unlock_flag}, 2'h2);
      end
      cmd(8'h20, 24'h01a345, 1'b1, 0, 0, 5'h00);
      chk(n_clr, 0);
      unl();
      cmd(8'h20, 24'h01a345, 1'b1, 0, 1, 5'h00);
      chk({n_clr[7:0], write_unlock_flag}, 9'h001);
      cmd(8'h02, 24'h0012fe, 1'b1, 2, 3, 5'h00);
      chk(wq.size(), 0);
      for (int i = 0; i < 7; i++) begin
         unl();
         cmd(ops[i], 24'hff8123, i < 3 || i > 4, i > 4, 0, 5'h01);
         chk(wq.size(), 0);
         chk(write_unlock_flag, i != 1);
      end
      for (int q = 0; q < 2; q++) begin
         unl();
         cmd(q ? 8'h32 : 8'h02, 24'h0012fe, 1'b1, 3, 0, 5'h00);
         chk(wq.size(), 3);
         chk({pend, write_unlock_flag}, 2'h2);
         for (int j = 0; j < 3; j++) begin
            chk(wq[j], {16'h0012, 8'hfe + j[7:0], h.dj(j)});
         end
      end
      unl();
      cmd(8'h02, 24'h000300, 1'b1, 258, 0, 5'h00);
      chk(wq.size(), 256);
      for (int k = 0; k < 256; k++) begin
         chk(wq[k], {16'h0003, k[7:0], h.dj(k < 2 ? k + 256 : k)});
      end
      finish_test();
   end
endmodule
`default_nettype wire
